/* src/pieb_pkg.sv */
// Package: register map, bit positions, reset values and carriers of the enable bank
package pieb_pkg;

  // Bus widths
  localparam int AW = 4;  // Register address width
  localparam int DW = 8;  // Register data width

  // Register offsets
  localparam logic [AW-1:0] OFS_ENABLE  = 4'h0;  // peripheral_irq_enable_one
  localparam logic [AW-1:0] OFS_CONTROL = 4'h1;  // irq_control_reg (bits 7 and 6 here)
  localparam logic [AW-1:0] OFS_FLAGS   = 4'h2;  // Source flags, cleared by a read

  // Enable and flag bit positions
  localparam int BIT_TIMER_GATE   = 7;  // timer_gate_irq_en
  localparam int BIT_CONVERTER    = 6;  // converter_irq_en
  localparam int BIT_SERIAL_RX    = 5;  // serial_rx_irq_en
  localparam int BIT_SERIAL_TX    = 4;  // serial_tx_irq_en
  localparam int BIT_SYNC_PORT    = 3;  // sync_port_irq_en
  localparam int BIT_CAPCOMP_ONE  = 2;  // capcomp_one_irq_en
  localparam int BIT_PERIOD_MATCH = 1;  // period_match_irq_en
  localparam int BIT_TIMER_OVF    = 0;  // timer_overflow_irq_en

  // Control register bit positions
  localparam int CTL_GLOBAL_BIT = 7;  // global_irq_enable
  localparam int CTL_PERIPH_BIT = 6;  // peripheral_group_enable

  // Reset values
  localparam logic [DW-1:0] ENABLE_RST  = 8'h00;
  localparam logic [DW-1:0] CONTROL_RST = 8'h00;
  localparam logic [DW-1:0] FLAGS_RST   = 8'h00;
  localparam logic [DW-1:0] RDATA_RST   = 8'h00;
  localparam logic [DW-1:0] UNMAPPED_RD = 8'h00;  // Answer to an unmapped read

  // One bit per source, bit 7 first, same layout as the enable register
  typedef struct packed {
    logic timer_gate;
    logic converter;
    logic serial_rx;
    logic serial_tx;
    logic sync_port;
    logic capcomp_one;
    logic period_match;
    logic timer_overflow;
  } pieb_src_t;

  // Register port request
  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic          wr;
    logic          rd;
  } pieb_bus_t;

endpackage : pieb_pkg

/* src/pieb_flags.sv */
// Sticky source flag bank with read-to-clear and set-over-clear priority
`timescale 1ns/10ps
module pieb_flags
  import pieb_pkg::*;
(
  // Clock and reset
  input  wire logic      clk,
  input  wire logic      resetn,
  // Events and clear
  input  wire pieb_src_t set_i,
  input  wire logic      clr_i,
  // Flag state
  output pieb_src_t      flags_o
);

  logic [DW-1:0] flag_reg;   // Held flags
  logic [DW-1:0] flag_next;  // Next flags

  // Per-bit next value; an event in the clearing cycle is kept
  genvar gi;
  generate
    for (gi = 0; gi < DW; gi++) begin : g_flag
      always_comb begin
        flag_next[gi] = set_i[gi] | (flag_reg[gi] & ~clr_i);  // [R12]
      end
    end
  endgenerate

  // Register stage
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flag_reg <= FLAGS_RST;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flags_o = pieb_src_t'(flag_reg);

endmodule : pieb_flags

/* src/pieb_gate.sv */
// Request gating: per-source enables, then group and global enables, registered
`timescale 1ns/10ps
module pieb_gate
  import pieb_pkg::*;
(
  // Clock and reset
  input  wire logic      clk,
  input  wire logic      resetn,
  // Qualifiers
  input  wire pieb_src_t flags_i,
  input  wire pieb_src_t enable_i,
  input  wire logic      periph_en_i,
  input  wire logic      global_en_i,
  // Request
  output logic           irq_o
);

  logic irq_reg;   // Registered request
  logic irq_next;  // Next request

  // OR of enabled flags, then the two shared enables
  always_comb begin
    irq_next = (|(flags_i & enable_i))  // [R14]
               & periph_en_i            // [R1] [R13]
               & global_en_i;           // [R11]
  end

  // Register stage keeps the output glitch free
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  assign irq_o = irq_reg;

endmodule : pieb_gate

/* src/pieb_top.sv */
// Top of the first peripheral interrupt enable bank with its register port
//
// What this block does
// R1 - No request without peripheral group enable set
// R2 - Bit 7 gates timer gate acquisition
// R3 - Bit 6 gates converter interrupt
// R4 - Bit 5 gates serial receive interrupt
// R5 - Bit 4 gates serial transmit interrupt
// R6 - Bit 3 gates synchronous port interrupt
// R7 - Bit 2 gates first capture/compare interrupt
// R8 - Bit 1 gates period match interrupt
// R9 - Bit 0 gates first timer overflow
// R10 - All enables read/write, zero after reset
// R11 - Global enable zero blocks every interrupt
// R12 - Flags set on events regardless of enables
// R13 - Group enable gates all peripheral requests
// R14 - Request is OR of flag AND enable
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module pieb_top
  import pieb_pkg::*;
(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          resetn,
  // Register port
  input  wire pieb_bus_t     bus_i,
  output logic    [DW-1:0]   rdata,
  // Source events, one-cycle pulses from same-clock peripherals
  input  wire pieb_src_t     events_i,
  // Interrupt request to the core
  output logic               irq
);

  // Address match used by both the write and the read path
  function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // Register map, one byte per offset:
  //   0x0  peripheral_irq_enable_one, one enable bit per source, read/write
  //   0x1  irq_control_reg, bit 7 global enable, bit 6 group enable, rest zero
  //   0x2  sticky source flags, read only, a read returns and clears them
  //   else writes ignored, reads answer zero
  // Flags latch whatever the enables hold, so software can poll a source
  // with its interrupt masked; the price is that a stale flag fires at once
  // when its enable is set, so clear the flags before enabling.
  //
  // Software state
  logic      [DW-1:0] en_reg;     // peripheral_irq_enable_one
  logic      [DW-1:0] en_next;
  logic      [DW-1:0] ctl_reg;    // irq_control_reg, bits 7 and 6 only
  logic      [DW-1:0] ctl_next;
  logic      [DW-1:0] rdata_reg;  // Read answer
  logic      [DW-1:0] rdata_next;
  pieb_src_t          flags_q;    // Sticky flags
  logic               flag_clr;   // Read of the flag register

  // Named views of the enable bits, also the gating mask; the names keep the
  // bit positions in one place, the package
  logic timer_gate_irq_en;
  logic converter_irq_en;
  logic serial_rx_irq_en;
  logic serial_tx_irq_en;
  logic sync_port_irq_en;
  logic capcomp_one_irq_en;
  logic period_match_irq_en;
  logic timer_overflow_irq_en;
  logic global_irq_enable;
  logic peripheral_group_enable;

  assign timer_gate_irq_en     = en_reg[BIT_TIMER_GATE];    // [R2]
  assign converter_irq_en      = en_reg[BIT_CONVERTER];     // [R3]
  assign serial_rx_irq_en      = en_reg[BIT_SERIAL_RX];     // [R4]
  assign serial_tx_irq_en      = en_reg[BIT_SERIAL_TX];     // [R5]
  assign sync_port_irq_en      = en_reg[BIT_SYNC_PORT];     // [R6]
  assign capcomp_one_irq_en    = en_reg[BIT_CAPCOMP_ONE];   // [R7]
  assign period_match_irq_en   = en_reg[BIT_PERIOD_MATCH];  // [R8]
  assign timer_overflow_irq_en = en_reg[BIT_TIMER_OVF];     // [R9]
  assign global_irq_enable       = ctl_reg[CTL_GLOBAL_BIT];
  assign peripheral_group_enable = ctl_reg[CTL_PERIPH_BIT];

  // Assemble the mask in source order so bit positions stay tied to names
  pieb_src_t enable_mask;
  always_comb begin
    enable_mask.timer_gate     = timer_gate_irq_en;
    enable_mask.converter      = converter_irq_en;
    enable_mask.serial_rx      = serial_rx_irq_en;
    enable_mask.serial_tx      = serial_tx_irq_en;
    enable_mask.sync_port      = sync_port_irq_en;
    enable_mask.capcomp_one    = capcomp_one_irq_en;
    enable_mask.period_match   = period_match_irq_en;
    enable_mask.timer_overflow = timer_overflow_irq_en;
  end

  // Next values of the writable registers
  always_comb begin
    en_next  = en_reg;
    ctl_next = ctl_reg;
    if (bus_i.wr && hit(bus_i.addr, OFS_ENABLE)) begin
      // Every enable bit is writable
      en_next = bus_i.wdata;  // [R10]
    end
    if (bus_i.wr && hit(bus_i.addr, OFS_CONTROL)) begin
      // Only the two shared enables live here; other bits stay zero
      ctl_next = CONTROL_RST;
      ctl_next[CTL_GLOBAL_BIT] = bus_i.wdata[CTL_GLOBAL_BIT];
      ctl_next[CTL_PERIPH_BIT] = bus_i.wdata[CTL_PERIPH_BIT];
    end
  end

  // Read answer; a flag read also clears the flags it returns. Writes to the
  // flag offset fall through both processes: the flags are read only.
  always_comb begin
    rdata_next = UNMAPPED_RD;
    flag_clr   = 1'b0;
    if (bus_i.rd) begin
      if (hit(bus_i.addr, OFS_ENABLE)) begin
        rdata_next = en_reg;  // [R10]
      end else if (hit(bus_i.addr, OFS_CONTROL)) begin
        rdata_next = ctl_reg;
      end else if (hit(bus_i.addr, OFS_FLAGS)) begin
        rdata_next = flags_q;
        flag_clr   = 1'b1;
      end else begin
        // Unmapped offsets answer zero and have no side effect
        rdata_next = UNMAPPED_RD;
      end
    end
  end

  // Register stage; every reset zeroes the enables, so no source can fire
  // until software has written both the enables and the control bits.
  // The read answer is a flop too, which keeps rdata off the address path.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      en_reg    <= ENABLE_RST;   // [R10]
      ctl_reg   <= CONTROL_RST;
      rdata_reg <= RDATA_RST;
    end else begin
      en_reg    <= en_next;
      ctl_reg   <= ctl_next;
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;

  // Flags latch independently of any enable; an event in the cycle of a flag
  // read wins over the clear, so no event is ever lost
  pieb_flags u_flags (
    .clk     (clk),
    .resetn  (resetn),
    .set_i   (events_i),  // [R12]
    .clr_i   (flag_clr),
    .flags_o (flags_q)
  );

  // Gating and registering of the request. irq trails the flags by one cycle;
  // the extra flop costs a cycle of latency but keeps decode glitches off
  // the request line.
  pieb_gate u_gate (
    .clk         (clk),
    .resetn      (resetn),
    .flags_i     (flags_q),
    .enable_i    (enable_mask),
    .periph_en_i (peripheral_group_enable),  // [R1] [R13]
    .global_en_i (global_irq_enable),        // [R11]
    .irq_o       (irq)
  );

  // Checks: all on clk, disabled in reset. Each per-bit check looks at one
  // raised flag so that the bit under test alone decides the request.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Helper: both shared enables set
  logic both_en;
  assign both_en = global_irq_enable & peripheral_group_enable;

  // Helpers: strobes decoded per register, shared by the checks below
  logic wr_enable;    // Write to the enable register
  logic wr_control;   // Write to the control register
  logic rd_flags;     // Read of the flag register
  logic rd_unmapped;  // Read of an offset that holds nothing
  assign wr_enable   = bus_i.wr && hit(bus_i.addr, OFS_ENABLE);
  assign wr_control  = bus_i.wr && hit(bus_i.addr, OFS_CONTROL);
  assign rd_flags    = bus_i.rd && hit(bus_i.addr, OFS_FLAGS);
  assign rd_unmapped = bus_i.rd && !hit(bus_i.addr, OFS_ENABLE)
                       && !hit(bus_i.addr, OFS_CONTROL) && !hit(bus_i.addr, OFS_FLAGS);

  // The group enable blocks everything while clear
  chk_group_blocks: assert property (  // [R1]
    !peripheral_group_enable |=> !irq)
    else $error("request raised with group enable clear");

  chk_bit7_gate: assert property (  // [R2]
    (flags_q == 8'h80 && both_en) |=> (irq == $past(en_reg[7])))
    else $error("bit 7 does not gate timer gate source");

  chk_bit6_gate: assert property (  // [R3]
    (flags_q == 8'h40 && both_en) |=> (irq == $past(en_reg[6])))
    else $error("bit 6 does not gate converter source");

  chk_bit5_gate: assert property (  // [R4]
    (flags_q == 8'h20 && both_en) |=> (irq == $past(en_reg[5])))
    else $error("bit 5 does not gate receive source");

  chk_bit4_gate: assert property (  // [R5]
    (flags_q == 8'h10 && both_en) |=> (irq == $past(en_reg[4])))
    else $error("bit 4 does not gate transmit source");

  chk_bit3_gate: assert property (  // [R6]
    (flags_q == 8'h08 && both_en) |=> (irq == $past(en_reg[3])))
    else $error("bit 3 does not gate sync port source");

  chk_bit2_gate: assert property (  // [R7]
    (flags_q == 8'h04 && both_en) |=> (irq == $past(en_reg[2])))
    else $error("bit 2 does not gate capture source");

  chk_bit1_gate: assert property (  // [R8]
    (flags_q == 8'h02 && both_en) |=> (irq == $past(en_reg[1])))
    else $error("bit 1 does not gate period match source");

  chk_bit0_gate: assert property (  // [R9]
    (flags_q == 8'h01 && both_en) |=> (irq == $past(en_reg[0])))
    else $error("bit 0 does not gate overflow source");

  // A write followed at once by a read of the enables returns the byte written
  chk_enable_rw: assert property (  // [R10]
    (bus_i.wr && bus_i.addr == OFS_ENABLE) ##1 (bus_i.rd && bus_i.addr == OFS_ENABLE)
    |=> (rdata == $past(bus_i.wdata, 2)))
    else $error("enable register does not read back its write");

  chk_global_blocks: assert property (  // [R11]
    !global_irq_enable |=> !irq)
    else $error("request raised with global enable clear");

  // Flags latch events whatever the enables hold
  chk_flag_sets: assert property (  // [R12]
    (events_i != 8'h00) |=> ((flags_q & $past(events_i)) == $past(events_i)))
    else $error("event lost or blocked by enables");

  chk_group_passes: assert property (  // [R13]
    (both_en && ((flags_q & en_reg) != 8'h00)) |=> irq)
    else $error("enabled request not raised");

  chk_request_sum: assert property (  // [R14]
    ##1 (irq == $past(|(flags_q & en_reg) & both_en)))
    else $error("request differs from gated flag sum");

  // Register port: the enable register takes every write and holds otherwise
  chk_enable_write: assert property (  // [R10]
    wr_enable |=> (en_reg == $past(bus_i.wdata)))
    else $error("enable register missed a write");

  chk_enable_hold: assert property (  // [R10]
    !wr_enable |=> $stable(en_reg))
    else $error("enable register changed without a write");

  // Only the two shared enables of the control register are stored
  chk_control_write: assert property (  // [R11] [R13]
    wr_control |=> (global_irq_enable == $past(bus_i.wdata[CTL_GLOBAL_BIT])
                    && peripheral_group_enable == $past(bus_i.wdata[CTL_PERIPH_BIT])))
    else $error("control register missed a write");

  // Read answer is zero outside the cycle after a read and for empty offsets
  chk_rdata_idle: assert property (  // [R10]
    !bus_i.rd |=> (rdata == 8'h00))
    else $error("read data not zero without a read");

  chk_unmapped_read: assert property (  // [R10]
    rd_unmapped |=> (rdata == 8'h00))
    else $error("unmapped offset answered non-zero");

  // Flags: read back, cleared by the read, sticky otherwise, set beats clear
  chk_flag_read: assert property (  // [R12]
    rd_flags |=> (rdata == $past(flags_q)))
    else $error("flag read returned wrong value");

  chk_flag_clear: assert property (  // [R12]
    (rd_flags && events_i == 8'h00) |=> (flags_q == 8'h00))
    else $error("flag read did not clear the flags");

  chk_flag_sticky: assert property (  // [R12]
    !rd_flags |=> ((flags_q & $past(flags_q)) == $past(flags_q)))
    else $error("flag dropped without a read");

  chk_set_over_clear: assert property (  // [R12]
    (rd_flags && events_i != 8'h00) |=> (flags_q == $past(events_i)))
    else $error("event lost in the clearing cycle");

  // No flag, no request, whatever the enables hold
  chk_irq_needs_flag: assert property (  // [R14]
    (flags_q == 8'h00) |=> !irq)
    else $error("request raised with no flag set");

  // Main scenarios
  cov_request:    cover property (both_en && (flags_q & en_reg) != 8'h00 ##1 irq);
  cov_masked:     cover property (flags_q != 8'h00 && en_reg == 8'h00 ##1 !irq);
  cov_set_clear:  cover property (flag_clr && events_i != 8'h00);
  cov_read_flags: cover property (bus_i.rd && bus_i.addr == OFS_FLAGS ##1 rdata != 8'h00);
  cov_wr_then_rd: cover property (wr_enable ##1 (bus_i.rd && bus_i.addr == OFS_ENABLE));

endmodule : pieb_top

/* tb/pieb_src_model.sv */
// Behavioural model of the peripheral event sources feeding the bank
`timescale 1ns/10ps
module pieb_src_model
  import pieb_pkg::*;
(
  // Clock and reset
  input  wire logic      clk,
  input  wire logic      resetn,
  // Bench requests, one cycle each
  input  wire pieb_src_t req_i,
  // Event pulses towards the bank
  output pieb_src_t      events_o
);
  // Sources change just after the edge, so the bank never sees a half-cycle pulse
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      events_o <= '0;  // Quiet while in reset
    end else begin
      events_o <= req_i;  // One-cycle pulse, one cycle behind the request
    end
  end
endmodule : pieb_src_model

/* tb/test_pieb_top.sv */
// Self-checking bench of the enable bank with random and corner stimulus
`timescale 1ns/10ps
`define CHECK(n, e, g) begin checks++; if ((e) !== (g)) begin n_fail++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module test_pieb_top;
  import pieb_pkg::*;
  logic          clk;     // 10 MHz clock
  logic          resetn;  // Active-low reset
  pieb_bus_t     bus;     // Register port request
  logic [DW-1:0] rdata;   // Read answer
  pieb_src_t     req;     // Requests to the source model
  pieb_src_t     events;  // Event pulses into the bank
  logic          irq;     // Request to the core
  int            checks;  // Comparisons made
  int            n_fail;  // Mismatches seen
  int            cyc;     // Cycles run, for the hang guard
  int            seed;    // Seed handle
  logic [DW-1:0] q;       // Read result
  logic [DW-1:0] en;      // Enable value under test
  logic [DW-1:0] ctl;     // Control value under test
  logic [DW-1:0] fl;      // Events fired

  pieb_top uut (.clk(clk), .resetn(resetn), .bus_i(bus), .rdata(rdata),
                .events_i(events), .irq(irq));
  pieb_src_model src (.clk(clk), .resetn(resetn), .req_i(req), .events_o(events));

  // Expected request: any enabled flag, gated by both control enables
  function automatic logic exp_irq(input logic [DW-1:0] f, e, c);
    return (|(f & e)) & c[CTL_GLOBAL_BIT] & c[CTL_PERIPH_BIT];
  endfunction : exp_irq

  // One-cycle write
  task automatic bus_wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : bus_wr

  // One-cycle read, data taken in the following cycle only
  task automatic bus_rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask : bus_rd

  // Write then read with no gap between the strobes
  task automatic bus_wr_rd(input logic [AW-1:0] a, input logic [DW-1:0] d,
                           output logic [DW-1:0] r);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 r = rdata;
  endtask : bus_wr_rd

  // Flag read in the very cycle in which the events reach the bank
  task automatic read_during_event(input logic [DW-1:0] v, output logic [DW-1:0] d);
    @(posedge clk);
    req <= pieb_src_t'(v);
    @(posedge clk);
    req <= '0;
    bus <= '{addr: OFS_FLAGS, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask : read_during_event

  // Fire events, then wait until the registered request has settled
  task automatic fire(input logic [DW-1:0] v);
    @(posedge clk);
    req <= pieb_src_t'(v);
    @(posedge clk);
    req <= '0;
    repeat (2) @(posedge clk);
    #1;
  endtask : fire

  // Read and clear the flags; the request must drop one cycle later
  task automatic clear_flags(input logic [DW-1:0] f);
    bus_rd(OFS_FLAGS, q);
    `CHECK("flags", f, q)
    @(posedge clk);
    #1;
    `CHECK("irq after clear", 1'b0, irq)
  endtask : clear_flags

  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      complete_run();
    end
  end

  // Main sequence
  initial begin
    resetn = 1'b0;
    bus = '0;
    req = '0;
    checks = 0;
    n_fail = 0;
    cyc = 0;
    seed = $urandom(50);
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    // Reset values of all three registers
    for (int a = 0; a < 3; a++) begin
      bus_rd(4'(a), q);
      `CHECK("reset value", 8'h00, q)
    end
    // Random write and read back of the enables
    for (int i = 0; i < 8; i++) begin
      en = 8'($urandom);
      if (i % 2 == 0) begin
        bus_wr(OFS_ENABLE, en);
        bus_rd(OFS_ENABLE, q);
      end else begin
        bus_wr_rd(OFS_ENABLE, en, q);
      end
      `CHECK("enable", en, q)
    end
    bus_wr(4'hf, 8'h5a);
    bus_rd(4'hf, q);
    `CHECK("unmapped", UNMAPPED_RD, q)
    // Each enable bit alone: others fire masked, its own source fires through
    bus_wr(OFS_CONTROL, 8'hc0);
    for (int b = 0; b < 8; b++) begin
      en = 8'h01 << b;
      bus_wr(OFS_ENABLE, en);
      fire(~en);
      `CHECK("irq masked", 1'b0, irq)
      clear_flags(~en);
      fire(en);
      `CHECK("irq enabled", 1'b1, irq)
      clear_flags(en);
      bus_wr(OFS_ENABLE, ~en);
      fire(en);
      `CHECK("irq own bit clear", 1'b0, irq)
      clear_flags(en);
    end
    // All four control combinations first, then random mixes
    for (int i = 0; i < 24; i++) begin
      ctl = (i < 4) ? {i[1:0], 6'h00} : {2'($urandom), 6'h00};
      en = (i < 4) ? 8'hff : 8'($urandom);
      fl = (i < 4) ? 8'hff : 8'($urandom);
      bus_wr(OFS_CONTROL, ctl);
      bus_wr(OFS_ENABLE, en);
      bus_rd(OFS_CONTROL, q);
      `CHECK("control", ctl, q)
      fire(fl);
      `CHECK("irq gated", exp_irq(fl, en, ctl), irq)
      clear_flags(fl);
    end
    // Events in the very cycle of a flag read outlive the clear
    for (int i = 0; i < 4; i++) begin
      fl = (i == 0) ? 8'hff : (8'($urandom) | 8'h01);
      read_during_event(fl, q);
      `CHECK("flags before race", 8'h00, q)
      clear_flags(fl);
    end
    // Reset in mid-run with a request standing clears every register again
    bus_wr(OFS_CONTROL, 8'hc0);
    bus_wr(OFS_ENABLE, 8'hff);
    fire(8'h42);
    `CHECK("irq before reset", 1'b1, irq)
    @(posedge clk);
    resetn <= 1'b0;
    @(posedge clk);
    resetn <= 1'b1;
    #1;
    `CHECK("irq after reset", 1'b0, irq)
    bus_rd(OFS_ENABLE, q);
    `CHECK("enable after reset", 8'h00, q)
    bus_rd(OFS_CONTROL, q);
    `CHECK("control after reset", 8'h00, q)
    bus_rd(OFS_FLAGS, q);
    `CHECK("flags after reset", 8'h00, q)
    complete_run();
  end
endmodule : test_pieb_top
